// [pkg/xlate_regs.vh]
// constants for the graphics address translation and buffer checking block
// assumes byte addresses of 32 bits and 4KB pages
`ifndef XLATE_REGS_VH
`define XLATE_REGS_VH
`define PAGE_SHIFT 12
`define PAGE_OFS_W 12
`define QWORD_MASK 32'h0000_0007
`define PAGE_MASK 32'h0000_0fff
`define RING_MAX_BYTES 32'h0020_0000
// table size codes
`define TSZ_64K 2'h0
`define TSZ_128K 2'h1
`define TSZ_256K 2'h2
`define TSZ_512K 2'h3
// entry counts per size (one entry per 4KB page)
`define ENT_64K 20'h04000
`define ENT_128K 20'h08000
`define ENT_256K 20'h10000
`define ENT_512K 20'h20000
// entry layout
`define ENT_VALID_BIT 0
`define ENT_FRAME_HI 31
`define ENT_FRAME_LO 12
// error codes
`define ERR_NONE 3'h0
`define ERR_RANGE 3'h1
`define ERR_INVALID 3'h2
`define ERR_ALIGN 3'h3
`define ERR_SIZE 3'h4
`endif

// [core/xlate_entry_cache.v]
// small last-entry store: remembers the most recent entry of each table
// assumes one lookup result is written at a time
`include "xlate_regs.vh"
module xlate_entry_cache (
    input wire clk,
    input wire rst,
    input wire flush,
    input wire wr_en,
    input wire wr_sel,
    input wire [19:0] wr_idx,
    input wire [31:0] wr_entry,
    input wire rd_sel,
    input wire [19:0] rd_idx,
    output reg hit,
    output reg [31:0] rd_entry
);
    reg [19:0] idx_r [0:1];
    reg [31:0] ent_r [0:1];
    reg vld_r [0:1];
    integer k;
    always @(posedge clk) begin
        if (rst || flush) begin
            for (k = 0; k < 2; k = k + 1) begin
                vld_r[k] <= 1'b0;
                idx_r[k] <= 20'h00000;
                ent_r[k] <= 32'h0000_0000;
            end
            hit <= 1'b0;
            rd_entry <= 32'h0000_0000;
        end else begin
            if (wr_en) begin
                vld_r[wr_sel] <= 1'b1;
                idx_r[wr_sel] <= wr_idx;
                ent_r[wr_sel] <= wr_entry;
            end
            hit <= vld_r[rd_sel] && (idx_r[rd_sel] == rd_idx);
            rd_entry <= ent_r[rd_sel];
        end
    end
endmodule

// [core/buffer_checker.v]
// placement checks for the status page, ring and batch buffers
// checks run every cycle; assumes configuration inputs are steady while the verdicts are used
`include "xlate_regs.vh"
module buffer_checker (
    input wire clk,
    input wire rst,
    input wire [31:0] status_page_address,
    input wire [31:0] ring_start,
    input wire [31:0] ring_length,
    input wire ring_tiled,
    input wire [31:0] batch_start,
    input wire [31:0] batch_end,
    output reg status_ok,
    output reg ring_ok,
    output reg batch_ok,
    output reg [31:0] batch_qwords
);
    function aligned;
        input [31:0] a;
        input [31:0] m;
        begin
            aligned = ((a & m) == 32'h0000_0000);
        end
    endfunction
    always @(posedge clk) begin
        if (rst) begin
            status_ok <= 1'b0;
            ring_ok <= 1'b0;
            batch_ok <= 1'b0;
            batch_qwords <= 32'h0000_0000;
        end else begin
            status_ok <= aligned(status_page_address, `PAGE_MASK);
            ring_ok <= aligned(ring_start, `PAGE_MASK) && !ring_tiled &&
                (ring_length != 32'h0000_0000) &&
                (ring_length <= `RING_MAX_BYTES);
            // end names the last valid qword; full 32-bit span allowed
            batch_ok <= aligned(batch_start, `QWORD_MASK) &&
                aligned(batch_end, `QWORD_MASK) &&
                (batch_end >= batch_start);
            batch_qwords <= ((batch_end - batch_start) >> 3) + 32'h1;
        end
    end
endmodule

// [core/graphics_xlate.v]
// address translation through global and per-process page tables
// assumes a memory read port that returns one 32-bit entry per request
//
// Behaviour
// R1: logical addresses map to physical through 32-bit entries in memory tables
// R2: table fetches are issued as non-snooped reads
// R3: table bases come from their control inputs and must be 4KB aligned
// R4: global table is contiguous and 128KB, 256KB or 512KB
// R5: per-process table may also be 64KB, selected by its control
// R6: software writes global entries only via the table aperture range
// R7: status page is an aligned 4KB page, written as snooped master
// R8: status page location comes from the status page address input
// R9: ring buffers start on 4KB boundaries in untiled memory
// R10: a ring buffer is at most 2MB long
// R11: indirect primitives sit in the same space as vertex buffers
// R12: batch buffers are contiguous streams entered by batch start command
// R13: batch buffer fetches are main memory reads without snooping
// R14: batch start and end are qword aligned; end is last qword
// R15: batch lengths up to the full 4GB span are accepted
// R16: each entry maps one 4KB page; index checked against table size
`include "xlate_regs.vh"
module graphics_xlate (
    input wire CLK_SYS,
    input wire SYS_RST,
    input wire [31:0] GLOBAL_TABLE_CONTROL,
    input wire [31:0] PER_PROCESS_TABLE_CONTROL,
    input wire [1:0] GLOBAL_TABLE_SIZE,
    input wire [1:0] PER_PROCESS_TABLE_SIZE,
    input wire TABLE_FLUSH,
    input wire XL_REQ,
    input wire XL_PER_PROCESS,
    input wire [31:0] XL_ADDR,
    output reg XL_READY,
    output reg XL_DONE,
    output reg [31:0] XL_PHYS,
    output reg [2:0] XL_ERR,
    output reg MEM_RD_REQ,
    output reg [31:0] MEM_RD_ADDR,
    output reg MEM_RD_SNOOP,
    input wire MEM_RD_VALID,
    input wire [31:0] MEM_RD_DATA,
    input wire [31:0] STATUS_PAGE_ADDRESS,
    output reg [31:0] STATUS_WR_BASE,
    output reg STATUS_WR_SNOOP,
    output reg STATUS_PAGE_OK,
    input wire [31:0] RING_START,
    input wire [31:0] RING_LENGTH,
    input wire RING_TILED,
    output reg RING_OK,
    input wire BATCH_START_CMD,
    input wire [31:0] BATCH_START_ADDR,
    input wire [31:0] BATCH_END_ADDR,
    output reg BATCH_OK,
    output reg BATCH_FETCH_SNOOP,
    output reg [31:0] BATCH_QWORDS,
    output reg BATCH_ACTIVE
);
    localparam ST_IDLE = 2'b00;
    localparam ST_LOOK = 2'b01;
    localparam ST_FETCH = 2'b10;
    localparam ST_WAIT = 2'b11;

    // entry count allowed for a size code
    function [19:0] entries;
        input [1:0] code;
        begin
            case (code)
                `TSZ_64K: entries = `ENT_64K;
                `TSZ_128K: entries = `ENT_128K;
                `TSZ_256K: entries = `ENT_256K;
                default: entries = `ENT_512K;
            endcase
        end
    endfunction

    function base_ok;
        input [31:0] b;
        begin
            base_ok = ((b & `PAGE_MASK) == 32'h0000_0000);
        end
    endfunction

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg sel_r;
    reg [19:0] idx_r;
    reg [11:0] ofs_r;
    reg ent_wr;
    reg [31:0] ent_wr_data;
    wire cache_hit;
    wire [31:0] cache_entry;
    wire status_ok;
    wire ring_ok;
    wire batch_ok;
    wire [31:0] batch_qwords;
    wire [31:0] cur_base;
    wire [1:0] cur_size;
    wire [19:0] req_idx;
    wire gbl_size_ok;

    assign req_idx = XL_ADDR[31:`PAGE_SHIFT]; // see R16
    assign cur_base = sel_r ? PER_PROCESS_TABLE_CONTROL : GLOBAL_TABLE_CONTROL;
    assign cur_size = sel_r ? PER_PROCESS_TABLE_SIZE : GLOBAL_TABLE_SIZE;
    // global table has no 64KB size
    assign gbl_size_ok = (GLOBAL_TABLE_SIZE != `TSZ_64K); // see R4

    xlate_entry_cache cache (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .flush(TABLE_FLUSH),
        .wr_en(ent_wr),
        .wr_sel(sel_r),
        .wr_idx(idx_r),
        .wr_entry(ent_wr_data),
        .rd_sel(sel_r),
        .rd_idx(idx_r),
        .hit(cache_hit),
        .rd_entry(cache_entry)
    );

    buffer_checker check (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .status_page_address(STATUS_PAGE_ADDRESS),
        .ring_start(RING_START),
        .ring_length(RING_LENGTH),
        .ring_tiled(RING_TILED),
        .batch_start(BATCH_START_ADDR),
        .batch_end(BATCH_END_ADDR),
        .status_ok(status_ok),
        .ring_ok(ring_ok),
        .batch_ok(batch_ok),
        .batch_qwords(batch_qwords)
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (XL_REQ) begin
                    state_nxt = ST_LOOK;
                end
            end
            ST_LOOK: begin
                state_nxt = ST_FETCH;
            end
            ST_FETCH: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (MEM_RD_VALID) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
            sel_r <= 1'b0;
            idx_r <= 20'h00000;
            ofs_r <= 12'h000;
            ent_wr <= 1'b0;
            ent_wr_data <= 32'h0000_0000;
            XL_READY <= 1'b0;
            XL_DONE <= 1'b0;
            XL_PHYS <= 32'h0000_0000;
            XL_ERR <= `ERR_NONE;
            MEM_RD_REQ <= 1'b0;
            MEM_RD_ADDR <= 32'h0000_0000;
            MEM_RD_SNOOP <= 1'b0;
        end else begin
            ent_wr <= 1'b0;
            XL_DONE <= 1'b0;
            MEM_RD_REQ <= 1'b0;
            MEM_RD_SNOOP <= 1'b0; // see R2
            XL_READY <= (state_nxt == ST_IDLE);
            case (state_r)
                ST_IDLE: begin
                    if (XL_REQ) begin
                        sel_r <= XL_PER_PROCESS;
                        idx_r <= req_idx;
                        ofs_r <= XL_ADDR[`PAGE_OFS_W-1:0];
                    end
                end
                ST_LOOK: begin
                    if (!base_ok(cur_base) ||
                        (!sel_r && !gbl_size_ok)) begin
                        // see R3
                        state_r <= ST_IDLE;
                        XL_DONE <= 1'b1;
                        XL_ERR <= `ERR_SIZE;
                        XL_PHYS <= 32'h0000_0000;
                        XL_READY <= 1'b1;
                    end else if (idx_r >= entries(cur_size)) begin
                        // see R16, R5
                        state_r <= ST_IDLE;
                        XL_DONE <= 1'b1;
                        XL_ERR <= `ERR_RANGE;
                        XL_PHYS <= 32'h0000_0000;
                        XL_READY <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    if (cache_hit) begin
                        state_r <= ST_IDLE;
                        XL_DONE <= 1'b1;
                        XL_READY <= 1'b1;
                        XL_ERR <= cache_entry[`ENT_VALID_BIT] ?
                            `ERR_NONE : `ERR_INVALID;
                        XL_PHYS <= {cache_entry[`ENT_FRAME_HI:`ENT_FRAME_LO],
                            ofs_r}; // see R1
                    end else begin
                        MEM_RD_REQ <= 1'b1;
                        MEM_RD_ADDR <= cur_base + {10'h000, idx_r, 2'b00};
                    end
                end
                ST_WAIT: begin
                    if (MEM_RD_VALID) begin
                        ent_wr <= 1'b1;
                        ent_wr_data <= MEM_RD_DATA;
                        XL_DONE <= 1'b1;
                        XL_ERR <= MEM_RD_DATA[`ENT_VALID_BIT] ?
                            `ERR_NONE : `ERR_INVALID;
                        XL_PHYS <= {MEM_RD_DATA[`ENT_FRAME_HI:`ENT_FRAME_LO],
                            ofs_r}; // see R1
                    end
                end
                default: begin
                    XL_ERR <= `ERR_NONE;
                end
            endcase
            if (!((state_r == ST_LOOK && (!base_ok(cur_base) ||
                (!sel_r && !gbl_size_ok) ||
                idx_r >= entries(cur_size))) ||
                (state_r == ST_FETCH && cache_hit))) begin
                state_r <= state_nxt;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            STATUS_WR_BASE <= 32'h0000_0000;
            STATUS_WR_SNOOP <= 1'b0;
            STATUS_PAGE_OK <= 1'b0;
            RING_OK <= 1'b0;
            BATCH_OK <= 1'b0;
            BATCH_FETCH_SNOOP <= 1'b0;
            BATCH_QWORDS <= 32'h0000_0000;
            BATCH_ACTIVE <= 1'b0;
        end else begin
            STATUS_WR_BASE <= STATUS_PAGE_ADDRESS & ~`PAGE_MASK; // see R8
            STATUS_WR_SNOOP <= 1'b1; // see R7
            STATUS_PAGE_OK <= status_ok; // see R7
            RING_OK <= ring_ok; // see R9, R10
            BATCH_OK <= batch_ok; // see R14, R15
            BATCH_FETCH_SNOOP <= 1'b0; // see R13
            BATCH_QWORDS <= batch_qwords;
            // a batch is entered only when its bounds pass the checks
            if (BATCH_START_CMD) begin
                BATCH_ACTIVE <= batch_ok; // see R12
            end
        end
    end
endmodule

// [tb/xlate_checker_assertions.sv]
// port assertions for the translation and buffer checking block
// assumes bind onto graphics_xlate; the bench holds XL_ADDR until done
`include "xlate_regs.vh"
module xlate_checker (
    input wire CLK_SYS,
    input wire SYS_RST,
    input wire [31:0] GLOBAL_TABLE_CONTROL,
    input wire [31:0] PER_PROCESS_TABLE_CONTROL,
    input wire [1:0] GLOBAL_TABLE_SIZE,
    input wire [1:0] PER_PROCESS_TABLE_SIZE,
    input wire XL_PER_PROCESS,
    input wire [31:0] XL_ADDR,
    input wire XL_DONE,
    input wire [2:0] XL_ERR,
    input wire MEM_RD_REQ,
    input wire [31:0] MEM_RD_ADDR,
    input wire MEM_RD_SNOOP,
    input wire MEM_RD_VALID,
    input wire [31:0] STATUS_PAGE_ADDRESS,
    input wire [31:0] STATUS_WR_BASE,
    input wire [31:0] RING_START,
    input wire [31:0] RING_LENGTH,
    input wire RING_TILED,
    input wire RING_OK,
    input wire [31:0] BATCH_START_ADDR,
    input wire [31:0] BATCH_END_ADDR,
    input wire BATCH_OK,
    input wire [31:0] BATCH_QWORDS
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    wire [31:0] tbase = XL_PER_PROCESS ? PER_PROCESS_TABLE_CONTROL :
        GLOBAL_TABLE_CONTROL;
    wire [1:0] tsz = XL_PER_PROCESS ? PER_PROCESS_TABLE_SIZE :
        GLOBAL_TABLE_SIZE;
    wire [31:0] bspan = BATCH_END_ADDR - BATCH_START_ADDR;
    a_rd_no_snoop: assert property (MEM_RD_REQ |-> !MEM_RD_SNOOP)
        else $error("entry read snooped");
    a_rd_entry_addr: assert property (MEM_RD_REQ |->
        MEM_RD_ADDR == tbase + {10'h0, XL_ADDR[31:12], 2'h0})
        else $error("entry read address wrong");
    a_fill_then_done: assert property (MEM_RD_VALID |=> XL_DONE)
        else $error("no answer after entry");
    a_index_in_range: assert property (
        XL_DONE && XL_ERR == `ERR_NONE |-> (XL_ADDR[31:12] >> (14 + tsz)) == 0)
        else $error("index beyond table accepted");
    a_status_base: assert property (
        $stable(STATUS_PAGE_ADDRESS)[*4] |->
        STATUS_WR_BASE == {STATUS_PAGE_ADDRESS[31:12], 12'h0})
        else $error("status base wrong");
    a_ring_ok: assert property (
        $stable({RING_START, RING_LENGTH, RING_TILED})[*4] |->
        RING_OK == (RING_START[11:0] == 0 && !RING_TILED &&
        RING_LENGTH != 0 && RING_LENGTH <= `RING_MAX_BYTES))
        else $error("ring verdict wrong");
    a_batch_ok: assert property (
        $stable({BATCH_START_ADDR, BATCH_END_ADDR})[*4] |-> BATCH_OK ==
        (((BATCH_START_ADDR | BATCH_END_ADDR) & `QWORD_MASK) == 0 &&
        BATCH_END_ADDR >= BATCH_START_ADDR))
        else $error("batch verdict wrong");
    a_batch_qwords: assert property (
        $stable({BATCH_START_ADDR, BATCH_END_ADDR})[*4] && BATCH_OK |->
        BATCH_QWORDS == (bspan >> 3) + 32'h1)
        else $error("batch length wrong");
    c_fill: cover property (MEM_RD_VALID ##1 XL_DONE);
    c_range: cover property (XL_DONE && XL_ERR == `ERR_RANGE);
    c_full: cover property (BATCH_OK && BATCH_QWORDS == 32'h2000_0000);
endmodule
bind graphics_xlate xlate_checker u_xlate_checker (.*);

// [tb/table_memory.sv]
// table memory model answering entry reads of the translation block
// assumes one read outstanding; slow adds wait cycles before the answer
module table_memory (
    input wire clk,
    input wire rst,
    input wire slow,
    input wire rd_req,
    input wire [31:0] rd_addr,
    output wire rd_valid,
    output wire [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] addr_r = 32'h0;
    logic [31:0] data_r = 32'h0;
    logic [3:0] wait_r = 4'h0;
    logic busy_r = 1'b0;
    logic valid_r = 1'b0;
    assign rd_valid = valid_r;
    assign rd_data = data_r;
    // entries are plain memory content set up by software
    // one memory space holds instructions and vertex data alike
    // data toggles between answers so a stale entry never looks fresh
    always @(posedge clk) begin
        valid_r <= 1'b0;
        data_r <= ~data_r;
        if (rst) begin
            busy_r <= 1'b0;
        end else if (rd_req) begin
            addr_r <= rd_addr;
            wait_r <= slow ? 4'h6 : 4'h0;
            busy_r <= 1'b1;
        end else if (busy_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_r) begin
            // word index ending in 111 holds an invalid entry
            valid_r <= 1'b1;
            data_r <= {addr_r[21:2] ^ 20'h3c5a1, 11'h0, ~&addr_r[4:2]};
            busy_r <= 1'b0;
        end
    end
endmodule

// [tb/testbench.sv]
// self-checking bench for the translation and buffer checking block
// assumes the table memory model on the entry read port
`include "xlate_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_SYS = 1'b0;
    logic SYS_RST = 1'b1;
    logic [31:0] GLOBAL_TABLE_CONTROL = 32'h0010_0000;
    logic [31:0] PER_PROCESS_TABLE_CONTROL = 32'h0020_3000;
    logic [1:0] GLOBAL_TABLE_SIZE = 2'h1;
    logic [1:0] PER_PROCESS_TABLE_SIZE = 2'h0;
    logic TABLE_FLUSH = 1'b0, XL_REQ = 1'b0, XL_PER_PROCESS = 1'b0;
    logic RING_TILED = 1'b0, BATCH_START_CMD = 1'b0, slow = 1'b0;
    logic [31:0] XL_ADDR = 32'h0, STATUS_PAGE_ADDRESS = 32'h0;
    logic [31:0] RING_START = 32'h0, RING_LENGTH = 32'h1000;
    logic [31:0] BATCH_START_ADDR = 32'h0, BATCH_END_ADDR = 32'h0;
    wire XL_READY, XL_DONE, MEM_RD_REQ, MEM_RD_SNOOP, MEM_RD_VALID;
    wire STATUS_WR_SNOOP, STATUS_PAGE_OK, RING_OK, BATCH_OK;
    wire BATCH_FETCH_SNOOP, BATCH_ACTIVE;
    wire [31:0] XL_PHYS, MEM_RD_ADDR, MEM_RD_DATA, STATUS_WR_BASE;
    wire [31:0] BATCH_QWORDS;
    wire [2:0] XL_ERR;
    int fails = 0, n_compared = 0, reads = 0;
    graphics_xlate u_graphics_xlate (.*);
    table_memory u_table_memory (.clk(CLK_SYS), .rst(SYS_RST), .slow(slow),
        .rd_req(MEM_RD_REQ), .rd_addr(MEM_RD_ADDR),
        .rd_valid(MEM_RD_VALID), .rd_data(MEM_RD_DATA));
    always #2 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) if (MEM_RD_REQ === 1'b1) reads <= reads + 1;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task xl(input logic pp, input logic [31:0] a, input logic sl);
        logic [31:0] b, ea;
        logic [1:0] sz;
        logic [2:0] err;
        int n;
        n = 0;
        do begin
            @(negedge CLK_SYS);
            n++;
        end while (XL_READY !== 1'b1 && n < 50);
        b = pp ? PER_PROCESS_TABLE_CONTROL : GLOBAL_TABLE_CONTROL;
        sz = pp ? PER_PROCESS_TABLE_SIZE : GLOBAL_TABLE_SIZE;
        ea = b + {a[31:12], 2'h0};
        err = (b[11:0] != 0 || (!pp && sz == 2'h0)) ? `ERR_SIZE :
            ((a[31:12] >> (14 + sz)) != 0) ? `ERR_RANGE :
            (&ea[4:2]) ? `ERR_INVALID : `ERR_NONE;
        @(posedge CLK_SYS);
        XL_REQ <= 1'b1;
        XL_PER_PROCESS <= pp;
        XL_ADDR <= a;
        slow <= sl;
        @(posedge CLK_SYS);
        XL_REQ <= 1'b0;
        @(negedge CLK_SYS);
        chk("xl_ready", 0, XL_READY);
        n = 0;
        while (XL_DONE !== 1'b1 && n < 50) begin
            @(negedge CLK_SYS);
            n++;
        end
        chk("xl_done", 1, XL_DONE);
        chk("xl_err", err, XL_ERR);
        if (err == `ERR_NONE)
            chk("xl_phys", {ea[21:2] ^ 20'h3c5a1, a[11:0]}, XL_PHYS);
    endtask
    task t_lookup;
        for (int s = 1; s < 4; s++) begin
            @(posedge CLK_SYS);
            GLOBAL_TABLE_SIZE <= s[1:0];
            PER_PROCESS_TABLE_SIZE <= s[1:0] - 2'h1;
            xl(1'b0, (32'h1 << (26 + s)) - 32'h6edc, s[0]);
            xl(1'b0, (32'h1 << (26 + s)) - 32'h1000, 1'b0);
            xl(1'b0, 32'h1 << (26 + s), 1'b0);
            xl(1'b1, (32'h1 << (25 + s)) - 32'h2ffc, 1'b1);
            xl(1'b1, 32'h1 << (25 + s), 1'b0);
        end
        @(posedge CLK_SYS);
        GLOBAL_TABLE_SIZE <= `TSZ_64K;
        xl(1'b0, 32'h0000_5abc, 1'b0);
        @(posedge CLK_SYS);
        PER_PROCESS_TABLE_CONTROL <= 32'h0020_3800;
        xl(1'b1, 32'h0000_5abc, 1'b0);
        @(posedge CLK_SYS);
        PER_PROCESS_TABLE_CONTROL <= 32'h0020_3000;
        GLOBAL_TABLE_SIZE <= `TSZ_512K;
    endtask
    task t_cache;
        int r0;
        xl(1'b0, 32'h0000_6010, 1'b1);
        r0 = reads;
        xl(1'b0, 32'h0000_6ff0, 1'b0);
        chk("hit_reads", r0, reads);
        @(posedge CLK_SYS);
        TABLE_FLUSH <= 1'b1;
        @(posedge CLK_SYS);
        TABLE_FLUSH <= 1'b0;
        xl(1'b0, 32'h0000_6004, 1'b0);
        chk("flush_reads", r0 + 1, reads);
    endtask
    task place(input logic [31:0] sp, rs, rl, input logic rt,
        input logic [31:0] bs, be);
        logic ok;
        @(posedge CLK_SYS);
        STATUS_PAGE_ADDRESS <= sp;
        RING_START <= rs;
        RING_LENGTH <= rl;
        RING_TILED <= rt;
        BATCH_START_ADDR <= bs;
        BATCH_END_ADDR <= be;
        repeat (3) @(posedge CLK_SYS);
        BATCH_START_CMD <= 1'b1;
        @(posedge CLK_SYS);
        BATCH_START_CMD <= 1'b0;
        @(negedge CLK_SYS);
        ok = ((bs | be) & `QWORD_MASK) == 0 && be >= bs;
        chk("status_base", {sp[31:12], 12'h0}, STATUS_WR_BASE);
        chk("status_ok", sp[11:0] == 0, STATUS_PAGE_OK);
        chk("status_snoop", 1, STATUS_WR_SNOOP);
        chk("ring_ok", rs[11:0] == 0 && !rt && rl != 0 &&
            rl <= `RING_MAX_BYTES, RING_OK);
        chk("batch_ok", ok, BATCH_OK);
        chk("batch_active", ok, BATCH_ACTIVE);
        chk("batch_snoop", 0, BATCH_FETCH_SNOOP);
        if (ok) chk("qwords", ((be - bs) >> 3) + 1, BATCH_QWORDS);
    endtask
    task t_place;
        place(32'h7fff_f000, 32'h0040_0000, `RING_MAX_BYTES, 1'b0, 32'h0,
            32'hffff_fff8);
        place(32'h7fff_f008, 32'h0040_0000, 32'h0020_0008, 1'b0, 32'h1008,
            32'h1008);
        place(32'h0, 32'h0040_0800, 32'h1000, 1'b0, 32'h1000,
            32'h1004);
        place(32'h0, 32'h0040_0000, 32'h1000, 1'b1, 32'h2000,
            32'h1ff8);
        place(32'h0, 32'h0040_0000, 32'h0, 1'b0, 32'h1004, 32'h2000);
    endtask
    task conclude;
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_lookup;
        t_cache;
        t_place;
        conclude;
    end
    initial begin
        #100000;
        fails++;
        conclude;
    end
endmodule
